// file: second_linear_regulator_ntc_ctrl.v
// second regulator and thermistor protection control registers
// assumes: host bus decoder delivers byte writes/reads on clock_in; pins are asynchronous
`timescale 1ns/1ps
`include "second_linear_regulator_ntc_regs.vh"

module regulator_thermistor_ctrl (
  input  wire       clock_in,
  input  wire       rst_b_in,
  input  wire       clk_en_in,
  input  wire       reg_reset_in,
  input  wire       wdog_expire_in,
  input  wire [7:0] addr_in,
  input  wire       wr_en_in,
  input  wire       rd_en_in,
  input  wire [7:0] wdata_in,
  input  wire [3:0] seq_slot_on_in,
  input  wire       first_general_pin_in,
  input  wire       regulator_good_in,
  output reg  [7:0] rdata_out,
  output reg        regulator_on_out,
  output reg        regulator_good_monitor_enable_out,
  output reg        temp_action_enable_out,
  output reg        temp_fault_battery_mode_enable_out,
  output reg        temp_fault_adapter_mode_enable_out,
  output reg        temp_charge_current_derate_out,
  output reg        temp_warm_voltage_derate_out,
  output reg        overtemp_lockout_enable_out,
  output reg  [7:0] charge_current_tenths_out,
  output reg  [7:0] warm_voltage_drop_mv_out
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg        pin_meta_r;
  reg        pin_sync_r;
  reg        good_meta_r;
  reg        good_sync_r;

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_meta_r  <= 1'b0;
      pin_sync_r  <= 1'b0;
      good_meta_r <= 1'b0;
      good_sync_r <= 1'b0;
    end else if (clk_en_in) begin
      pin_meta_r  <= first_general_pin_in;
      pin_sync_r  <= pin_meta_r;
      good_meta_r <= regulator_good_in;
      good_sync_r <= good_meta_r;
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function [1:0] addr_hit;
    input [7:0] addr;
    begin
      if (addr == `REG_CTRL_OFFSET) begin
        addr_hit = 2'b01;
      end else if (addr == `THERM_CTRL_OFFSET) begin
        addr_hit = 2'b10;
      end else begin
        addr_hit = 2'b00;
      end
    end
  endfunction

  wire [1:0] hit           = addr_hit(addr_in);

  // ----------------------------------------
  // regulator control register
  // ----------------------------------------
  reg  [2:0] en_sel_r;
  reg        good_mon_r;
  wire       wr_reg_ctrl   = wr_en_in && hit[0];
  wire       wr_therm_ctrl = wr_en_in && hit[1];
  wire [7:0] therm_q;

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      en_sel_r   <= `REG_EN_SEL_RESET;
      good_mon_r <= `REG_GOOD_MON_RESET;
    end else if (clk_en_in) begin
      if (reg_reset_in) begin
        en_sel_r   <= `REG_EN_SEL_RESET;
        good_mon_r <= `REG_GOOD_MON_RESET;
      end else if (wr_reg_ctrl) begin
        en_sel_r   <= wdata_in[`REG_EN_SEL_MSB:`REG_EN_SEL_LSB];
        good_mon_r <= wdata_in[`REG_GOOD_MON_BIT];
      end
    end
  end

  reg_pair_mem u_therm (
    .clock_in     (clock_in),
    .rst_b_in     (rst_b_in),
    .clk_en_in    (clk_en_in),
    .reg_reset_in (reg_reset_in),
    .wdog_in      (wdog_expire_in),
    .wr_in        (wr_therm_ctrl),
    .wdata_in     (wdata_in),
    .value_out    (therm_q)
  );

  // ----------------------------------------
  // enable decode
  // ----------------------------------------
  function sel_on;
    input [2:0] sel;
    input [3:0] slots;
    input       pin;
    begin
      if (sel == `REG_EN_SLOT_A) begin
        sel_on = slots[0];
      end else if (sel == `REG_EN_SLOT_B) begin
        sel_on = slots[1];
      end else if (sel == `REG_EN_SLOT_C) begin
        sel_on = slots[2];
      end else if (sel == `REG_EN_SLOT_D) begin
        sel_on = slots[3];
      end else if (sel == `REG_EN_OFF) begin
        sel_on = 1'b0;
      end else if (sel == `REG_EN_ON) begin
        sel_on = 1'b1;
      end else if (sel == `REG_EN_PIN) begin
        sel_on = pin;
      end else begin
        sel_on = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------
  // derating figures
  // ----------------------------------------
  function [7:0] current_tenths;
    input fifth;
    begin
      if (fifth) begin
        current_tenths = `CUR_DERATE_FIFTH_NUM;
      end else begin
        current_tenths = `CUR_DERATE_HALF_NUM;
      end
    end
  endfunction

  function [7:0] voltage_drop_mv;
    input deeper;
    begin
      if (deeper) begin
        voltage_drop_mv = `VOLT_DERATE_HIGH_MV;
      end else begin
        voltage_drop_mv = `VOLT_DERATE_LOW_MV;
      end
    end
  endfunction

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  reg [7:0] rdata_nxt;

  always @* begin
    rdata_nxt = rdata_out;
    if (rd_en_in) begin
      if (hit[0]) begin
        rdata_nxt = 8'h00;
        rdata_nxt[`REG_EN_SEL_MSB:`REG_EN_SEL_LSB] = en_sel_r;
        rdata_nxt[`REG_GOOD_MON_BIT]  = good_mon_r;
        rdata_nxt[`REG_GOOD_FLAG_BIT] = good_sync_r;
      end else if (hit[1]) begin
        rdata_nxt = therm_q;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out                          <= 8'h00;
      regulator_on_out                   <= 1'b0;
      regulator_good_monitor_enable_out  <= 1'b0;
      temp_action_enable_out             <= 1'b0;
      temp_fault_battery_mode_enable_out <= 1'b0;
      temp_fault_adapter_mode_enable_out <= 1'b0;
      temp_charge_current_derate_out     <= 1'b0;
      temp_warm_voltage_derate_out       <= 1'b0;
      overtemp_lockout_enable_out        <= 1'b0;
      charge_current_tenths_out          <= 8'h00;
      warm_voltage_drop_mv_out           <= 8'h00;
    end else if (clk_en_in) begin
      rdata_out                          <= rdata_nxt;
      regulator_on_out                   <= sel_on(en_sel_r, seq_slot_on_in, pin_sync_r);
      regulator_good_monitor_enable_out  <= good_mon_r;
      temp_action_enable_out             <= therm_q[`TEMP_ACTION_BIT];
      temp_fault_battery_mode_enable_out <= therm_q[`TEMP_BATT_MON_BIT];
      temp_fault_adapter_mode_enable_out <= therm_q[`TEMP_ADPT_MON_BIT];
      temp_charge_current_derate_out     <= therm_q[`TEMP_CUR_DERATE_BIT];
      temp_warm_voltage_derate_out       <= therm_q[`TEMP_VOLT_DERATE_BIT];
      overtemp_lockout_enable_out        <= therm_q[`TEMP_LOCKOUT_BIT];
      charge_current_tenths_out          <= current_tenths(therm_q[`TEMP_CUR_DERATE_BIT]);
      warm_voltage_drop_mv_out           <= voltage_drop_mv(therm_q[`TEMP_VOLT_DERATE_BIT]);
    end
  end

endmodule

// file: second_linear_regulator_ntc_regs.vh
// offsets, field positions and reset values of the regulator/thermistor control pair
// assumes: included by bare name from the design files
`ifndef REG_THERM_CTRL_REGS_VH
`define REG_THERM_CTRL_REGS_VH

// ----------------------------------------
// offsets
// ----------------------------------------
`define REG_CTRL_OFFSET        8'h3E
`define THERM_CTRL_OFFSET      8'h3F

// ----------------------------------------
// regulator control fields
// ----------------------------------------
`define REG_EN_SEL_MSB         7
`define REG_EN_SEL_LSB         5
`define REG_GOOD_MON_BIT       3
`define REG_GOOD_FLAG_BIT      1
`define REG_EN_SEL_RESET       3'h4
`define REG_GOOD_MON_RESET     1'h1
`define REG_EN_SLOT_A          3'h0
`define REG_EN_SLOT_B          3'h1
`define REG_EN_SLOT_C          3'h2
`define REG_EN_SLOT_D          3'h3
`define REG_EN_OFF             3'h4
`define REG_EN_ON              3'h5
`define REG_EN_PIN             3'h6
`define REG_EN_ALWAYS          3'h7

// ----------------------------------------
// thermistor control fields
// ----------------------------------------
`define TEMP_ACTION_BIT        7
`define TEMP_BATT_MON_BIT      6
`define TEMP_ADPT_MON_BIT      5
`define TEMP_CUR_DERATE_BIT    4
`define TEMP_VOLT_DERATE_BIT   3
`define TEMP_LOCKOUT_BIT       2
`define THERM_CTRL_RESET       8'hA0
`define THERM_WRITE_MASK       8'hFC

// ----------------------------------------
// derating figures
// ----------------------------------------
`define CUR_DERATE_HALF_NUM    8'h05
`define CUR_DERATE_FIFTH_NUM   8'h02
`define VOLT_DERATE_LOW_MV     8'h64
`define VOLT_DERATE_HIGH_MV    8'hC8
`define ADPT_MON_PERIOD_MS     8'h1E

`endif

// file: reg_pair_mem.v
// reg_pair_mem.v: thermistor control byte storage with registered read data
// assumes: single clock, write mask and reset values from the header
`timescale 1ns/1ps
`include "second_linear_regulator_ntc_regs.vh"

module reg_pair_mem (
  input  wire       clock_in,
  input  wire       rst_b_in,
  input  wire       clk_en_in,
  input  wire       reg_reset_in,
  input  wire       wdog_in,
  input  wire       wr_in,
  input  wire [7:0] wdata_in,
  output reg  [7:0] value_out
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      value_out <= `THERM_CTRL_RESET;
    end else if (clk_en_in) begin
      if (reg_reset_in) begin
        value_out <= `THERM_CTRL_RESET;
      end else if (wr_in) begin
        value_out <= wdata_in & `THERM_WRITE_MASK;
      end else if (wdog_in) begin
        value_out[`TEMP_BATT_MON_BIT] <= 1'b0;
        value_out[`TEMP_ADPT_MON_BIT] <= 1'b1;
      end
    end
  end

endmodule

// file: second_linear_regulator_ntc_chk.sv
// port assertions for the regulator/thermistor control pair
// assumes: bound to regulator_thermistor_ctrl, one clock, async active-low reset
`timescale 1ns/1ps
module regulator_thermistor_chk (
  input logic       clock_in,
  input logic       rst_b_in,
  input logic       clk_en_in,
  input logic       reg_reset_in,
  input logic       wdog_expire_in,
  input logic [7:0] addr_in,
  input logic       wr_en_in,
  input logic       rd_en_in,
  input logic [7:0] wdata_in,
  input logic [3:0] seq_slot_on_in,
  input logic [7:0] rdata_out,
  input logic       regulator_on_out,
  input logic       regulator_good_monitor_enable_out,
  input logic       temp_action_enable_out,
  input logic       temp_fault_battery_mode_enable_out,
  input logic       temp_fault_adapter_mode_enable_out,
  input logic       temp_charge_current_derate_out,
  input logic       temp_warm_voltage_derate_out,
  input logic       overtemp_lockout_enable_out,
  input logic [7:0] charge_current_tenths_out,
  input logic [7:0] warm_voltage_drop_mv_out
);
  wire [5:0] tf = {temp_action_enable_out, temp_fault_battery_mode_enable_out, temp_fault_adapter_mode_enable_out,
                   temp_charge_current_derate_out, temp_warm_voltage_derate_out, overtemp_lockout_enable_out};
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_wr(a);
    clk_en_in && wr_en_in && addr_in == a && !reg_reset_in ##1 clk_en_in;
  endsequence
  therm_write_a: assert property (s_wr(8'h3F) |-> ##1 tf == $past(wdata_in[7:2], 2))
    else $error("thermistor outputs do not follow write");
  monitor_write_a: assert property (s_wr(8'h3E) |-> ##1 regulator_good_monitor_enable_out == $past(wdata_in[3], 2))
    else $error("monitor enable does not follow write");
  fixed_enable_a: assert property (s_wr(8'h3E) ##0 $past(wdata_in[7:5]) inside {3'h4, 3'h5, 3'h7}
    |-> ##1 regulator_on_out == ($past(wdata_in[7:5], 2) != 3'h4)) else $error("fixed enable code wrong");
  slot_enable_a: assert property (s_wr(8'h3E) ##0 !$past(wdata_in[7])
    |-> ##1 regulator_on_out == |($past(seq_slot_on_in) & (4'h1 << $past(wdata_in[6:5], 2)))) else $error("slot wrong");
  derate_map_a: assert property ($past(clk_en_in) && $past(rst_b_in) |->
    charge_current_tenths_out == (temp_charge_current_derate_out ? 8'h02 : 8'h05) &&
    warm_voltage_drop_mv_out == (temp_warm_voltage_derate_out ? 8'hC8 : 8'h64)) else $error("derate figure wrong");
  reg_reset_a: assert property (clk_en_in && reg_reset_in ##1 clk_en_in |-> ##1 tf == 6'h28 &&
    regulator_good_monitor_enable_out && !regulator_on_out) else $error("register reset values wrong");
  watchdog_reset_a: assert property (clk_en_in && wdog_expire_in && !wr_en_in && !reg_reset_in ##1 clk_en_in
    |-> ##1 !temp_fault_battery_mode_enable_out && temp_fault_adapter_mode_enable_out) else $error("watchdog wrong");
  unmapped_read_a: assert property (clk_en_in && rd_en_in && !(addr_in inside {8'h3E, 8'h3F})
    |=> rdata_out == 8'h00) else $error("unmapped read not zero");
  reserved_read_a: assert property (clk_en_in && rd_en_in
    |=> (rdata_out & ($past(addr_in) == 8'h3E ? 8'h15 : 8'h03)) == 8'h00) else $error("reserved bit set");
endmodule
bind regulator_thermistor_ctrl regulator_thermistor_chk regulator_thermistor_chk_inst (.*);

// file: second_linear_regulator_load_model.sv
// behavioural regulator output, good level lags the enable
// assumes: enable comes from the block under test on the same clock
`timescale 1ns/1ps
module regulator_load_model (
  input  logic clock_in,
  input  logic enable_in,
  output logic good_out
);
  logic ramp_r = 1'b0;
  initial good_out = 1'b0;
  always @(posedge clock_in) begin
    ramp_r   <= enable_in;
    good_out <= ramp_r;
  end
endmodule

// file: testbench.sv
// testbench.sv: register access scenarios for the regulator/thermistor control pair
// assumes: design, load model and checker compiled first
`timescale 1ns/1ps
module testbench;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       rrst = 1'b0;
  logic       wdog = 1'b0;
  logic [7:0] addr = 8'h00;
  logic       wr = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [3:0] slots = 4'h0;
  logic       pin = 1'b0;
  logic       ce = 1'b1;
  logic       exp_on;
  wire        good, on, mon, act, bat, adp, cdr, vdr, lck;
  wire  [7:0] rdata, cur, drop;
  int         n_errors = 0;
  int         samples_checked = 0;
  int         code;
  always #5 clk = ~clk;
  regulator_thermistor_ctrl regulator_thermistor_ctrl_inst (.clock_in(clk), .rst_b_in(rst_b), .clk_en_in(ce),
    .reg_reset_in(rrst),
    .wdog_expire_in(wdog), .addr_in(addr), .wr_en_in(wr), .rd_en_in(rd_en), .wdata_in(wdata), .seq_slot_on_in(slots),
    .first_general_pin_in(pin), .regulator_good_in(good), .rdata_out(rdata), .regulator_on_out(on),
    .regulator_good_monitor_enable_out(mon), .temp_action_enable_out(act), .temp_fault_battery_mode_enable_out(bat),
    .temp_fault_adapter_mode_enable_out(adp), .temp_charge_current_derate_out(cdr),
    .temp_warm_voltage_derate_out(vdr), .overtemp_lockout_enable_out(lck), .charge_current_tenths_out(cur),
    .warm_voltage_drop_mv_out(drop));
  regulator_load_model regulator_load_model_inst (.clock_in(clk), .enable_in(on), .good_out(good));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd_en = 1'b1;
    cyc(1);
    rd_en = 1'b0;
    chk(rdata, exp);
    cyc(1);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    cyc(3);
    rst_b = 1'b1;
    cyc(1);
    rd_reg(8'h3E, 8'h88);
    rd_reg(8'h3F, 8'hA0);
    wr_reg(8'h3F, 8'hFF);
    cyc(2);
    chk({2'b00, act, bat, adp, cdr, vdr, lck}, 8'h3F);
    chk(cur, 8'h02);
    chk(drop, 8'hC8);
    rd_reg(8'h3F, 8'hFC);
    wr_reg(8'h3F, 8'h40);
    cyc(2);
    chk(cur, 8'h05);
    chk(drop, 8'h64);
    wdog = 1'b1;
    cyc(1);
    wdog = 1'b0;
    rd_reg(8'h3F, 8'h20);
    rd_reg(8'h3D, 8'h00);
    for (code = 0; code < 8; code++) begin
      slots = (code < 4) ? 4'h1 << code : 4'h0;
      pin = 1'b1;
      exp_on = (code != 4);
      wr_reg(8'h3E, {code[2:0], 5'h1F});
      cyc(8);
      chk(on, exp_on);
      rd_reg(8'h3E, {code[2:0], 3'b010, exp_on, 1'b0});
    end
    slots = 4'hB;
    wr_reg(8'h3E, 8'h48);
    cyc(2);
    chk(on, 1'b0);
    slots = 4'h4;
    cyc(2);
    chk(on, 1'b1);
    wr_reg(8'h3E, 8'hC0);
    pin = 1'b0;
    cyc(4);
    chk(on, 1'b0);
    chk(mon, 1'b0);
    pin = 1'b1;
    cyc(4);
    chk(on, 1'b1);
    wr_reg(8'h3F, 8'hFF);
    rrst = 1'b1;
    cyc(1);
    rrst = 1'b0;
    cyc(8);
    rd_reg(8'h3E, 8'h88);
    rd_reg(8'h3F, 8'hA0);
    ce = 1'b0;
    wr_reg(8'h3F, 8'h00);
    ce = 1'b1;
    rd_reg(8'h3F, 8'hA0);
    end_of_test();
  end
endmodule
